/* File: include/cpw_pkg.sv */
// Constants, field layout and mode codes for the modulated-output timer unit.
// Assumes a 32-bit APB slave, one word per register, registers in the low byte lanes.
package cpw_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] CPW_OFS_UNIT_CONTROL = 8'h00;
	localparam logic [7:0] CPW_OFS_DUTY_UPPER = 8'h04;
	localparam logic [7:0] CPW_OFS_DUTY_SHADOW = 8'h08;
	localparam logic [7:0] CPW_OFS_PERIOD_LIMIT = 8'h0c;
	localparam logic [7:0] CPW_OFS_PERIOD_COUNTER = 8'h10;
	localparam logic [7:0] CPW_OFS_TIMER_CONTROL = 8'h14;
	localparam logic [7:0] CPW_OFS_FLAGS = 8'h18;
	localparam logic [7:0] CPW_OFS_PIN_DIRECTION = 8'h1c;

	// ==========================================================
	// Field positions
	localparam int CPW_CTL_MODE_LSB = 0;
	localparam int CPW_CTL_DLOW_LSB = 4;
	localparam int CPW_TCTL_PS_LSB = 0;
	localparam int CPW_TCTL_RUN_BIT = 2;
	localparam int CPW_TCTL_POST_LSB = 3;
	localparam int CPW_FLG_PERIOD_BIT = 0;
	localparam int CPW_FLG_EVENT_BIT = 1;

	// ==========================================================
	// Reset values
	localparam logic [5:0] CPW_RST_CONTROL = 6'h00;
	localparam logic [7:0] CPW_RST_DUTY = 8'h00;
	localparam logic [7:0] CPW_RST_LIMIT = 8'hff;
	localparam logic [7:0] CPW_RST_COUNT = 8'h00;
	localparam logic [6:0] CPW_RST_TCTL = 7'h00;
	localparam logic CPW_RST_DIR = 1'b1;

	// ==========================================================
	// Mode select codes
	localparam logic [3:0] CPW_MODE_OFF = 4'h0;
	localparam logic [3:0] CPW_MODE_CMP_TOGGLE = 4'h2;
	localparam logic [3:0] CPW_MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] CPW_MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] CPW_MODE_CAP_RISE4 = 4'h6;
	localparam logic [3:0] CPW_MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] CPW_MODE_CMP_SET = 4'h8;
	localparam logic [3:0] CPW_MODE_CMP_CLEAR = 4'h9;
	localparam logic [3:0] CPW_MODE_CMP_SWINT = 4'ha;
	localparam logic [3:0] CPW_MODE_CMP_TRIG = 4'hb;

	// Timer prescale select codes
	localparam logic [1:0] CPW_PS_DIV1 = 2'h0;
	localparam logic [1:0] CPW_PS_DIV4 = 2'h1;

	// ==========================================================
	// Timing: one timer step is four oscillator periods
	localparam int CPW_OSC_PER_STEP = 4;
	localparam logic [1:0] CPW_PHASE_LAST = 2'(CPW_OSC_PER_STEP - 1);
	localparam logic [3:0] CPW_PRESC_LAST = 4'hf;
	localparam logic [1:0] CPW_PRESC4_LAST = 2'h3;
	localparam logic [3:0] CPW_CAP4_LAST = 4'h3;
	localparam logic [3:0] CPW_CAP16_LAST = 4'hf;

	typedef enum logic [1:0] {
		CPW_BUS_IDLE = 2'b01,
		CPW_BUS_ACCESS = 2'b10
	} cpw_bus_t;
endpackage

/* File: sim/cpw_load_model.sv */
// Load on the modulated pin, with a weak source that takes over when released.
// Assumes pclk is the unit clock; the bench clears the high-cycle count.
module cpw_load_model (
	input wire logic pclk,
	input wire logic pin_out,
	input wire logic pin_oe_n,
	input wire logic src_level,
	input wire logic clr,
	output logic pin_level,
	output int hi_cnt,
	output int period
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_q = 1'b0;
	int since_q = 0;
	// Released pin follows the source, so a stale drive never lingers
	assign pin_level = pin_oe_n ? src_level : pin_out;
	// High cycles and rise-to-rise spacing, sampled on the clock edge
	always @(posedge pclk)
	begin
		last_q <= pin_level;
		since_q <= (pin_level && !last_q) ? 1 : since_q + 1;
		if (pin_level && !last_q)
			period <= since_q;
		hi_cnt <= clr ? 0 : hi_cnt + int'(pin_level);
	end
endmodule // cpw_load_model

/* File: sim/cpw_unit_properties.sv */
// Concurrent checks on the modulated-output unit, seen from its top-level ports.
// Assumes one clock pclk and presetn asynchronous, active low.
module cpw_unit_properties #(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic wave_pin_out,
	input wire logic wave_pin_oe_n,
	input wire logic sleep_req,
	input wire logic converter_enable,
	input wire logic conversion_start
);
	timeunit 1ns;
	timeprecision 1ps;
	import cpw_pkg::*;
	logic [3:0] mode_q;
	logic dir_q;
	logic wr_done;
	logic drive_ok;
	logic trig;
	// ==========================================================
	// Shadow copies of mode and direction, taken at the write edge
	assign wr_done = psel && penable && pready && pwrite;
	assign trig = mode_q == CPW_MODE_CMP_TRIG;
	assign drive_ok = !dir_q && (mode_q[3:2] == 2'b11 || mode_q == CPW_MODE_CMP_TOGGLE
		|| mode_q == CPW_MODE_CMP_SET || mode_q == CPW_MODE_CMP_CLEAR);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_q <= CPW_MODE_OFF;
			dir_q <= CPW_RST_DIR;
		end
		else if (wr_done && paddr[7:0] == CPW_OFS_UNIT_CONTROL)
			mode_q <= pwdata[3:0];
		else if (wr_done && paddr[7:0] == CPW_OFS_PIN_DIRECTION)
			dir_q <= pwdata[0];
	end
	// ==========================================================
	// Properties; registered outputs may lag the shadows by one edge
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_reset_idle;
		$rose(presetn) |-> wave_pin_oe_n && !wave_pin_out && !pready;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("pin not idle after reset");
	property p_answer;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_answer: assert property (p_answer) else $error("apb answer not one cycle");
	property p_ctl_read;
		pready && !pwrite && paddr[7:0] == CPW_OFS_UNIT_CONTROL |-> prdata[31:6] == 26'h0;
	endproperty
	a_ctl_read: assert property (p_ctl_read) else $error("control upper bits set");
	property p_unmapped;
		pready && paddr[7:0] > CPW_OFS_PIN_DIRECTION |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_release;
		wr_done && paddr[7:0] == CPW_OFS_UNIT_CONTROL && pwdata[5:0] == 6'h0
			|=> ##[0:1] wave_pin_oe_n && !wave_pin_out;
	endproperty
	a_release: assert property (p_release) else $error("pin kept after off");
	property p_drive;
		!wave_pin_oe_n |-> drive_ok || $past(drive_ok);
	endproperty
	a_drive: assert property (p_drive) else $error("pin driven in wrong mode");
	property p_sleep;
		sleep_req [*5] |-> $stable(wave_pin_out);
	endproperty
	a_sleep: assert property (p_sleep) else $error("pin moved in sleep");
	property p_conv;
		conversion_start |-> (converter_enable || $past(converter_enable)) && (trig || $past(trig));
	endproperty
	a_conv: assert property (p_conv) else $error("stray conversion start");
	c_release: cover property (wr_done && pwdata[5:0] == 6'h0);
	c_conv: cover property (conversion_start);
	c_sleep: cover property (sleep_req [*5]);
endmodule // cpw_unit_properties

/* File: sim/tb_cpw_unit.sv */
// Self-checking bench for the modulated-output unit over APB.
// Assumes the checker and load model files are compiled first.
module tb_cpw_unit;
	timeunit 1ns;
	timeprecision 1ps;
	import cpw_pkg::*;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} cpw_row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pin_level;
	logic wave_pin_out;
	logic wave_pin_oe_n;
	logic sleep_req = 1'b0;
	logic conv_en = 1'b0;
	logic conversion_start;
	logic src_level = 1'b0;
	logic clr = 1'b0;
	int hi_cnt;
	int period;
	int convs = 0;
	int num_errors = 0;
	int checked = 0;
	logic [31:0] rd;
	logic rd_err;
	cpw_row_t rows [9] = '{'{0, 8'h00, 0, 0}, '{0, 8'h0c, 0, 32'hff}, '{0, 8'h10, 0, 0},
		'{0, 8'h1c, 0, 1}, '{0, 8'h18, 0, 0}, '{1, 8'h00, 32'hff, 32'h3f},
		'{1, 8'h08, 32'h55, 0}, '{1, 8'h04, 32'ha5, 32'ha5}, '{0, 8'h20, 0, 0}};
	// Compare codes: bit6 check level, bit5 level, bit4 released, bits3-0 code
	logic [6:0] cmp [5] = '{7'h02, 7'h68, 7'h49, 7'h1a, 7'h1b};
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) if (conversion_start === 1'b1) convs <= convs + 1;
	cpw_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wave_pin_in(pin_level), .wave_pin_out(wave_pin_out),
		.wave_pin_oe_n(wave_pin_oe_n), .sleep_req(sleep_req), .converter_enable(conv_en),
		.conversion_start(conversion_start));
	cpw_load_model load_u (.pclk(pclk), .pin_out(wave_pin_out), .pin_oe_n(wave_pin_oe_n),
		.src_level(src_level), .clr(clr), .pin_level(pin_level), .hi_cnt(hi_cnt),
		.period(period));
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge pclk);
		end
		if (n == 20)
		begin
			num_errors++;
			$display("wrong value at %0t: no answer from the slave", $time);
		end
		rd = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Two periods to settle, then high cycles over four whole periods
	task automatic measure(input int p);
		repeat (2 * p) @(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		repeat (4 * p) @(posedge pclk);
		#1;
	endtask
	task automatic finish_test();
		$display("errors %0d, checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ==========================================================
	// Watchdog: the whole sequence needs well under 60 us
	initial
	begin
		#200us;
		num_errors++;
		finish_test();
	end
	// ==========================================================
	// Main sequence
	initial
	begin
		int n;
		int a;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i])
		begin
			if (rows[i].wr) apb(1, rows[i].a, rows[i].d);
			apb(0, rows[i].a, 0);
			chk(rd, rows[i].e);
			chk(rd_err, rows[i].a > CPW_OFS_PIN_DIRECTION);
		end
		// Documented bring-up order, pin enabled after the first rollover
		apb(1, CPW_OFS_PERIOD_LIMIT, 32'h3);
		apb(1, CPW_OFS_UNIT_CONTROL, 32'h2c);
		apb(1, CPW_OFS_DUTY_UPPER, 32'h1);
		apb(1, CPW_OFS_FLAGS, 32'h3);
		apb(1, CPW_OFS_TIMER_CONTROL, 32'h7c);
		n = 0;
		rd = 0;
		while (rd[0] !== 1'b1 && n < 30)
		begin
			apb(0, CPW_OFS_FLAGS, 0);
			n++;
		end
		chk(rd[0], 1);
		apb(1, CPW_OFS_PIN_DIRECTION, 32'h0);
		// Duty 6 of 16 at each prescale; postscale bits all set
		for (int ps = 0; ps < 3; ps++)
		begin
			apb(1, CPW_OFS_TIMER_CONTROL, 32'h7c | ps);
			measure(16 << (2 * ps));
			chk(period, 16 << (2 * ps));
			chk(hi_cnt, 24 << (2 * ps));
			chk(wave_pin_oe_n, 0);
		end
		apb(1, CPW_OFS_TIMER_CONTROL, 32'h04);
		apb(1, CPW_OFS_DUTY_UPPER, 32'h2);
		measure(16);
		chk(hi_cnt, 40);
		apb(0, CPW_OFS_DUTY_SHADOW, 0);
		chk(rd, 2);
		sleep_req <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(0, CPW_OFS_PERIOD_COUNTER, 0);
		a = rd;
		repeat (20) @(posedge pclk);
		apb(0, CPW_OFS_PERIOD_COUNTER, 0);
		chk(rd, a);
		sleep_req <= 1'b0;
		apb(1, CPW_OFS_UNIT_CONTROL, 32'h0c);
		apb(1, CPW_OFS_DUTY_UPPER, 32'h0);
		measure(16);
		chk(hi_cnt, 0);
		apb(1, CPW_OFS_DUTY_UPPER, 32'h8);
		measure(16);
		chk(hi_cnt, 64);
		// Compare codes, match at counter value 1
		apb(1, CPW_OFS_DUTY_UPPER, 32'h1);
		conv_en <= 1'b1;
		foreach (cmp[i])
		begin
			apb(1, CPW_OFS_UNIT_CONTROL, cmp[i][3:0]);
			repeat (40) @(posedge pclk);
			chk(wave_pin_oe_n, cmp[i][4]);
			if (cmp[i][6]) chk(wave_pin_out, cmp[i][5]);
		end
		apb(0, CPW_OFS_FLAGS, 0);
		chk(rd[1], 1);
		chk(convs != 0, 1);
		apb(1, CPW_OFS_UNIT_CONTROL, 32'h08);
		apb(1, CPW_OFS_UNIT_CONTROL, 32'h00);
		repeat (3) @(posedge pclk);
		chk({wave_pin_oe_n, wave_pin_out}, 2'b10);
		// Capture codes, sixteen rises on the released pin
		for (int m = 4; m < 8; m++)
		begin
			apb(1, CPW_OFS_FLAGS, 32'h3);
			apb(1, CPW_OFS_UNIT_CONTROL, m);
			repeat (32)
			begin
				repeat (4) @(posedge pclk);
				src_level <= ~src_level;
			end
			apb(0, CPW_OFS_FLAGS, 0);
			chk(rd[1], 1);
		end
		apb(1, CPW_OFS_UNIT_CONTROL, 32'h0c);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({wave_pin_oe_n, wave_pin_out}, 2'b10);
		presetn <= 1'b1;
		apb(0, CPW_OFS_UNIT_CONTROL, 0);
		chk(rd, 0);
		finish_test();
	end
endmodule // tb_cpw_unit
bind cpw_unit cpw_unit_properties #(.ADDR_W(ADDR_W)) chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .wave_pin_out(wave_pin_out),
	.wave_pin_oe_n(wave_pin_oe_n), .sleep_req(sleep_req),
	.converter_enable(converter_enable), .conversion_start(conversion_start));

/* File: verilog/cpw_unit.sv */
// Capture/compare/modulated-output timer unit with an APB register slave.
// Assumes pclk is the oscillator clock, capture pin and sleep request are asynchronous,
// and converter_enable comes from logic on pclk.
module cpw_unit #(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic wave_pin_in,
	output logic wave_pin_out,
	output logic wave_pin_oe_n,
	input wire logic sleep_req,
	input wire logic converter_enable,
	output logic conversion_start
);
	import cpw_pkg::*;

	// ==========================================================
	// Elaboration check
	generate
		if (ADDR_W < 5 || ADDR_W > 8)
		begin : g_bad_addr
			$error("cpw_unit: ADDR_W must lie between 5 and 8");
		end
	endgenerate

	// ==========================================================
	// State
	typedef struct packed {
		logic cap_s1, cap_s2, cap_prev, slp_s1, slp_s2;
		logic [1:0] phase;
		logic [3:0] presc;
		logic [3:0] cap_cnt;
		logic [5:0] ctrl;
		logic [7:0] duty_up;
		logic [7:0] shadow;
		logic [1:0] latch;
		logic [7:0] limit;
		logic [7:0] count;
		logic [6:0] tctl;
		logic flag_pm, flag_ev, dir, wave, oe_n, trig;
		cpw_bus_t bus;
		logic [31:0] rdata;
		logic ready, err;
	} cpw_state_t;

	cpw_state_t s_q;
	cpw_state_t s_d;

	// ==========================================================
	// Mode decode helpers
	function automatic logic is_pwm(input logic [3:0] m);
		is_pwm = (m[3:2] == 2'b11);
	endfunction

	function automatic logic is_capture(input logic [3:0] m);
		is_capture = (m[3:2] == 2'b01);
	endfunction

	// Software-interrupt and trigger modes leave the pin alone
	function automatic logic drives_pin(input logic [3:0] m);
		drives_pin = is_pwm(m) || m == CPW_MODE_CMP_TOGGLE || m == CPW_MODE_CMP_SET
			|| m == CPW_MODE_CMP_CLEAR;
	endfunction

	function automatic logic [31:0] word8(input logic [7:0] v);
		word8 = {24'h000000, v};
	endfunction

	// Register read mux; unmapped offsets flag an error
	function automatic logic [32:0] rd_mux(input cpw_state_t s, input logic [7:0] a);
		rd_mux = {1'b0, 32'h00000000};
		case (a)
			CPW_OFS_UNIT_CONTROL: rd_mux[31:0] = word8({2'b00, s.ctrl});
			CPW_OFS_DUTY_UPPER: rd_mux[31:0] = word8(s.duty_up);
			CPW_OFS_DUTY_SHADOW: rd_mux[31:0] = word8(s.shadow);
			CPW_OFS_PERIOD_LIMIT: rd_mux[31:0] = word8(s.limit);
			CPW_OFS_PERIOD_COUNTER: rd_mux[31:0] = word8(s.count);
			CPW_OFS_TIMER_CONTROL: rd_mux[31:0] = word8({1'b0, s.tctl});
			CPW_OFS_FLAGS: rd_mux[31:0] = word8({6'h00, s.flag_ev, s.flag_pm});
			CPW_OFS_PIN_DIRECTION: rd_mux[31:0] = word8({7'h00, s.dir});
			default: rd_mux[32] = 1'b1;
		endcase
	endfunction

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		logic [7:0] addr;
		logic [3:0] mode;
		logic [1:0] ps, tb_low;
		logic run, quarter, step, rollover, cmp_hit, cap_edge, cap_evt, wr;
		logic [32:0] rd;
		logic [9:0] new_duty;
		addr = 8'(paddr);
		mode = s_q.ctrl[CPW_CTL_MODE_LSB +: 4];
		ps = s_q.tctl[CPW_TCTL_PS_LSB +: 2];
		run = s_q.tctl[CPW_TCTL_RUN_BIT] && !s_q.slp_s2;
		quarter = 1'b0;
		step = 1'b0;
		tb_low = 2'h0;
		rollover = 1'b0;
		cmp_hit = 1'b0;
		cap_edge = 1'b0;
		cap_evt = 1'b0;
		wr = 1'b0;
		rd = 33'h000000000;
		new_duty = 10'h000;
		s_d = s_q;

		// Synchronisers for the pin and the sleep request
		s_d.cap_s1 = wave_pin_in;
		s_d.cap_s2 = s_q.cap_s1;
		s_d.slp_s1 = sleep_req;
		s_d.slp_s2 = s_q.slp_s1;
		s_d.trig = 1'b0;

		// Prescaler chain: phase counts oscillator periods, presc counts steps
		quarter = run && (s_q.phase == CPW_PHASE_LAST);
		case (ps)
			CPW_PS_DIV1: step = quarter;
			CPW_PS_DIV4: step = quarter && (s_q.presc[1:0] == CPW_PRESC4_LAST);
			default: step = quarter && (s_q.presc == CPW_PRESC_LAST);
		endcase
		if (run)
		begin
			s_d.phase = s_q.phase + 2'h1;
		end
		if (quarter)
		begin
			s_d.presc = s_q.presc + 4'h1;
		end
		// Low time-base bits of the coming cycle; the postscaler field never enters here
		case (ps)
			CPW_PS_DIV1: tb_low = s_d.phase;
			CPW_PS_DIV4: tb_low = s_d.presc[1:0];
			default: tb_low = s_d.presc[3:2];
		endcase

		// Period counter and rollover
		rollover = step && (s_q.count == s_q.limit);
		if (rollover)
		begin
			s_d.count = CPW_RST_COUNT;
			s_d.flag_pm = 1'b1;
		end
		else if (step)
		begin
			s_d.count = s_q.count + 8'h01;
		end

		// Modulation mode: duty too large never matches, so the pin just holds
		new_duty = {s_q.duty_up, s_q.ctrl[CPW_CTL_DLOW_LSB +: 2]};
		if (is_pwm(mode))
		begin
			if (rollover)
			begin
				s_d.shadow = s_q.duty_up;
				s_d.latch = s_q.ctrl[CPW_CTL_DLOW_LSB +: 2];
				s_d.wave = (new_duty != 10'h000);
			end
			// Match on the coming time base: the registered pin is then low from
			// the first matching count, so the pulse lasts exactly the duty value
			if (run && {s_d.count, tb_low} == {s_d.shadow, s_d.latch})
			begin
				s_d.wave = 1'b0;
			end
		end

		// Compare modes match the counter against the upper duty bits
		cmp_hit = step && (s_q.count == s_q.duty_up);
		if (cmp_hit)
		begin
			case (mode)
				CPW_MODE_CMP_TOGGLE: s_d.wave = !s_q.wave;
				CPW_MODE_CMP_SET:
				begin
					s_d.wave = 1'b1;
					s_d.flag_ev = 1'b1;
				end
				CPW_MODE_CMP_CLEAR:
				begin
					s_d.wave = 1'b0;
					s_d.flag_ev = 1'b1;
				end
				CPW_MODE_CMP_SWINT: s_d.flag_ev = 1'b1;
				CPW_MODE_CMP_TRIG:
				begin
					s_d.flag_ev = 1'b1;
					s_d.trig = converter_enable;
				end
				default: s_d.wave = s_q.wave;
			endcase
		end

		// Capture modes: edge detect on the synchronised pin, then edge prescale
		s_d.cap_prev = s_q.cap_s2;
		if (is_capture(mode) && !s_q.slp_s2)
		begin
			if (mode == CPW_MODE_CAP_FALL)
			begin
				cap_edge = s_q.cap_prev && !s_q.cap_s2;
			end
			else
			begin
				cap_edge = !s_q.cap_prev && s_q.cap_s2;
			end
			case (mode)
				CPW_MODE_CAP_RISE4: cap_evt = cap_edge && (s_q.cap_cnt[1:0] == CPW_CAP4_LAST[1:0]);
				CPW_MODE_CAP_RISE16: cap_evt = cap_edge && (s_q.cap_cnt == CPW_CAP16_LAST);
				default: cap_evt = cap_edge;
			endcase
			if (cap_edge)
			begin
				s_d.cap_cnt = s_q.cap_cnt + 4'h1;
			end
		end
		else if (!is_capture(mode))
		begin
			s_d.cap_cnt = 4'h0;
		end

		// Unit off: pin level, capture count and duty latch back to rest
		if (mode == CPW_MODE_OFF)
		begin
			s_d.wave = 1'b0;
			s_d.cap_cnt = 4'h0;
			s_d.latch = 2'h0;
		end

		// APB: setup cycle prepares the answer, access cycle completes with zero waits
		s_d.ready = 1'b0;
		s_d.err = 1'b0;
		case (s_q.bus)
			CPW_BUS_IDLE:
			begin
				if (psel && !penable)
				begin
					rd = rd_mux(s_q, addr);
					s_d.rdata = pwrite ? 32'h00000000 : rd[31:0];
					s_d.err = rd[32];
					s_d.ready = 1'b1;
					s_d.bus = CPW_BUS_ACCESS;
				end
			end
			CPW_BUS_ACCESS:
			begin
				wr = psel && penable && pwrite && s_q.ready && !s_q.err;
				s_d.bus = CPW_BUS_IDLE;
			end
			default: s_d.bus = CPW_BUS_IDLE;
		endcase

		// Register writes; hardware events win over software clears
		if (wr)
		begin
			case (addr)
				CPW_OFS_UNIT_CONTROL: s_d.ctrl = pwdata[5:0];
				CPW_OFS_DUTY_UPPER:
				begin
					if (!cap_evt)
					begin
						s_d.duty_up = pwdata[7:0];
					end
				end
				CPW_OFS_DUTY_SHADOW:
				begin
					if (!is_pwm(mode))
					begin
						s_d.shadow = pwdata[7:0];
					end
				end
				CPW_OFS_PERIOD_LIMIT: s_d.limit = pwdata[7:0];
				CPW_OFS_PERIOD_COUNTER: s_d.count = pwdata[7:0];
				CPW_OFS_TIMER_CONTROL: s_d.tctl = pwdata[6:0];
				CPW_OFS_FLAGS:
				begin
					if (pwdata[CPW_FLG_PERIOD_BIT] && !rollover)
					begin
						s_d.flag_pm = 1'b0;
					end
					if (pwdata[CPW_FLG_EVENT_BIT]
						&& !((cmp_hit && mode[3:2] == CPW_MODE_CMP_SET[3:2]) || cap_evt))
					begin
						s_d.flag_ev = 1'b0;
					end
				end
				CPW_OFS_PIN_DIRECTION: s_d.dir = pwdata[0];
				default: s_d.dir = s_q.dir;
			endcase
		end
		if (cap_evt)
		begin
			s_d.duty_up = s_q.count;
			s_d.flag_ev = 1'b1;
		end

		// Pin is driven only when direction is output and the mode owns it
		s_d.oe_n = s_d.dir || !drives_pin(s_d.ctrl[CPW_CTL_MODE_LSB +: 4]);
	end

	// ==========================================================
	// State register: reset clears control, pin goes to input
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q <= '0;
			s_q.ctrl <= CPW_RST_CONTROL;
			s_q.duty_up <= CPW_RST_DUTY;
			s_q.shadow <= CPW_RST_DUTY;
			s_q.limit <= CPW_RST_LIMIT;
			s_q.count <= CPW_RST_COUNT;
			s_q.tctl <= CPW_RST_TCTL;
			s_q.dir <= CPW_RST_DIR;
			s_q.oe_n <= 1'b1;
			s_q.bus <= CPW_BUS_IDLE;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs straight from the state register
	assign prdata = s_q.rdata;
	assign pready = s_q.ready;
	assign pslverr = s_q.err;
	assign wave_pin_out = s_q.wave;
	assign wave_pin_oe_n = s_q.oe_n;
	assign conversion_start = s_q.trig;
endmodule // cpw_unit
